// ---- shared/mic_pkg.sv ----
package mic_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned PHASES         = 4;
  localparam logic [12:0] VECTOR_ADDR    = 13'h0004;
  localparam int unsigned DUMMY_CYCLES   = 2;
  localparam logic [1:0]  ADDR_CTRL      = 2'h0;
  localparam logic [1:0]  ADDR_PFLAG     = 2'h1;
  localparam logic [1:0]  ADDR_PEN       = 2'h2;
  localparam logic [1:0]  ADDR_OPTION    = 2'h3;
  localparam int unsigned B_PORT_FLAG    = 0;
  localparam int unsigned B_PIN_FLAG     = 1;
  localparam int unsigned B_TMR_FLAG     = 2;
  localparam int unsigned B_PORT_EN      = 3;
  localparam int unsigned B_PIN_EN       = 4;
  localparam int unsigned B_TMR_EN       = 5;
  localparam int unsigned B_PERIPH_EN    = 6;
  localparam int unsigned B_GLOBAL_EN    = 7;
  localparam int unsigned B_CONV         = 6;
  localparam int unsigned B_EDGE_SEL     = 6;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  PERIPH_RESET   = 8'h00;
  localparam logic [7:0]  OPTION_RESET   = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;

  typedef struct packed {
    logic        pop;        // return-from-interrupt executed
    logic [12:0] pc;         // address of the next instruction
  } mic_core_t;

  typedef struct packed {
    logic        push;       // push return address
    logic        load;       // load program counter
    logic [12:0] addr;       // vector address
  } mic_vec_t;
endpackage : mic_pkg

// ---- logic/mic_sync.sv ----
`timescale 1ns/1ps
module mic_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clk_sys_i, // system clock
  input  wire logic             sys_rst_i, // synchronous reset
  input  wire logic [WIDTH-1:0] async_i,   // pins from outside
  output logic      [WIDTH-1:0] sync_o,    // filtered level
  output logic      [WIDTH-1:0] chg_o      // one-cycle change pulse
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] held;
  wire  [WIDTH-1:0] agree = ~(s2 ^ s3);

  if (WIDTH < 1)
  begin : g_width_check
    $error("synchroniser width must be at least one");
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk_sys_i)
  begin
    s1 <= async_i;
    s2 <= s1;
    s3 <= s2;
    if (sys_rst_i)
    begin
      // Loading the settled level keeps a pin that already sits high
      // from looking like a fresh edge once reset lets go.
      held  <= s3;
      chg_o <= '0;
    end
    else
    begin
      held  <= (held & ~agree) | (s3 & agree);
      chg_o <= agree & (s3 ^ held);
    end
  end
  assign sync_o = held;
endmodule : mic_sync

// ---- logic/mic_ctrl.sv ----
`timescale 1ns/1ps
module mic_ctrl (
  input  wire logic          clk_sys_i,  // system clock, 250 MHz
  input  wire logic          sys_rst_i,  // synchronous reset
  input  wire logic [1:0]    addr_i,     // register address
  input  wire logic [7:0]    wdata_i,    // write data
  input  wire logic          wr_i,       // write strobe
  input  wire logic          rd_i,       // read strobe
  output logic      [7:0]    rdata_o,    // read data, cycle after strobe
  input  wire logic          tmr_ovf_i,  // timer rollover pulse
  input  wire logic          conv_done_i,// conversion done pulse
  input  wire logic          ext_irq_pin_i, // external interrupt pin
  input  wire logic [2:0]    port_pins_i,// monitored port pins
  input  wire mic_pkg::mic_core_t core_i,// core status
  output mic_pkg::mic_vec_t  vec_o,      // vector request to core
  output logic               dummy_o,    // discard fetched instruction
  output logic [1:0]         phase_o     // current phase, 0 = first
);
  import mic_pkg::*;

  typedef enum {ST_RUN, ST_DUMMY} mic_st_t;
  mic_st_t state;

  logic [7:0] ctrl;
  logic [7:0] pflag;
  logic [7:0] pen;
  logic [7:0] option;
  logic [1:0] phase;
  logic [1:0] dummy_cnt;
  logic [4:0] pin_lvl;
  logic [4:0] pin_chg;
  logic       vec_req_q;

  mic_sync #(.WIDTH(5)) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({port_pins_i, ext_irq_pin_i, 1'b0}),
    .sync_o    (pin_lvl),
    .chg_o     (pin_chg)
  );

  // Four sources only; each event pulse derives from its own input.
  wire ev_tmr  = tmr_ovf_i;
  wire ev_conv = conv_done_i;
  wire ev_port = |pin_chg[4:2];
  // The pin flag may land in any phase, so the last-to-first window is met.
  wire ev_pin  = pin_chg[1] &
                 (pin_lvl[1] == option[B_EDGE_SEL]);

  wire phase_last  = (phase == 2'(PHASES - 1));
  wire phase_first = (phase == 2'h0);

  wire wr_ctrl  = wr_i && addr_i == ADDR_CTRL;
  wire wr_pflag = wr_i && addr_i == ADDR_PFLAG;
  wire wr_pen   = wr_i && addr_i == ADDR_PEN;
  wire wr_opt   = wr_i && addr_i == ADDR_OPTION;

  // Request sum, sampled only at the first phase of each cycle.
  wire any_req = (ctrl[B_TMR_FLAG]  & ctrl[B_TMR_EN])  |
                 (ctrl[B_PIN_FLAG]  & ctrl[B_PIN_EN])  |
                 (ctrl[B_PORT_FLAG] & ctrl[B_PORT_EN]) |
                 (pflag[B_CONV] & pen[B_CONV] &
                  ctrl[B_PERIPH_EN]);
  wire accept  = phase_first && state == ST_RUN &&
                 ctrl[B_GLOBAL_EN] && any_req;

  // Software writes first, hardware sets on top so events are never lost.
  wire [7:0] ctrl_sw = wr_ctrl ? wdata_i : ctrl;
  wire [7:0] ctrl_set = {1'b0, 4'h0, ev_tmr, ev_pin, ev_port};
  logic [7:0] next_ctrl;
  always_comb
  begin
    next_ctrl = ctrl_sw | ctrl_set;
    if (accept)
      next_ctrl[B_GLOBAL_EN] = 1'b0;
    else if (core_i.pop)
      next_ctrl[B_GLOBAL_EN] = 1'b1;
  end

  wire [7:0] next_pflag = (wr_pflag ? wdata_i : pflag) |
                          (8'(ev_conv) << B_CONV);

  wire [7:0] rd_mux = (addr_i == ADDR_CTRL)  ? ctrl  :
                      (addr_i == ADDR_PFLAG) ? pflag :
                      (addr_i == ADDR_PEN)   ? pen   : option;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ctrl   <= CTRL_RESET;
      pflag  <= PERIPH_RESET;
      pen    <= PERIPH_RESET;
      option <= OPTION_RESET;
      phase  <= 2'h0;
      rdata_o <= BYTE_ZERO;
    end
    else
    begin
      ctrl   <= next_ctrl;
      pflag  <= next_pflag;
      pen    <= wr_pen ? wdata_i : pen;
      option <= wr_opt ? wdata_i : option;
      phase  <= phase + 2'h1;
      rdata_o <= rd_i ? rd_mux : BYTE_ZERO;
    end
  end

  // Vectoring does not care whether the current instruction is one or two
  // cycles long, so latency stays fixed at four clocks.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state     <= ST_RUN;
      dummy_cnt <= 2'h0;
      vec_req_q <= 1'b0;
      vec_o     <= '0;
      dummy_o   <= 1'b0;
    end
    else
    begin
      vec_o <= '0;
      if (accept)
        vec_req_q <= 1'b1;
      unique case (state)
        ST_RUN:
        begin
          if (vec_req_q && phase_last)
          begin
            state     <= ST_DUMMY;
            dummy_cnt <= 2'(DUMMY_CYCLES);
            dummy_o   <= 1'b1;
            vec_o     <= '{push: 1'b1, load: 1'b1,
                           addr: VECTOR_ADDR};
            vec_req_q <= 1'b0;
          end
        end
        ST_DUMMY:
        begin
          if (phase_last)
          begin
            dummy_cnt <= dummy_cnt - 2'h1;
            if (dummy_cnt == 2'h1)
            begin
              state   <= ST_RUN;
              dummy_o <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      phase_o <= 2'h0;
    else
      phase_o <= phase + 2'h1;
  end

  a_reset_gie: assert property (@(posedge clk_sys_i)
    sys_rst_i |=> !ctrl[B_GLOBAL_EN])
    else $error("global enable not cleared by reset");
  a_accept_gie: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    accept |=> !ctrl[B_GLOBAL_EN])
    else $error("global enable kept after accept");
  a_pop_gie: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    core_i.pop && !accept |=> ctrl[B_GLOBAL_EN])
    else $error("return did not set global enable");
  a_tmr_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    tmr_ovf_i |=> ctrl[B_TMR_FLAG])
    else $error("timer flag not set");
  a_conv_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    conv_done_i |=> pflag[B_CONV])
    else $error("conversion flag not set");
  a_no_gie_block: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !ctrl[B_GLOBAL_EN] |-> !accept)
    else $error("accept without global enable");
  a_vec_latency: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    accept |-> ##[3:4] vec_o.load)
    else $error("vector not issued in time");
  a_vec_addr: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    vec_o.load |-> vec_o.push && vec_o.addr == VECTOR_ADDR)
    else $error("bad vector");
  a_dummy_len: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(dummy_o) |-> dummy_o [*8])
    else $error("dummy cycles too short");
  a_flag_kept: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ctrl[B_PIN_FLAG] && !wr_ctrl |=> ctrl[B_PIN_FLAG])
    else $error("pin flag cleared by hardware");

  c_vector: cover property (@(posedge clk_sys_i) vec_o.load);
  c_pin_edge: cover property (@(posedge clk_sys_i) ev_pin);
  c_port_chg: cover property (@(posedge clk_sys_i) ev_port);
  c_return: cover property (@(posedge clk_sys_i) core_i.pop);
  c_dummy_end: cover property (@(posedge clk_sys_i) $fell(dummy_o));

  // A port change must leave its flag behind, whatever the enables say.
  a_port_flag: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ev_port |=> ctrl[B_PORT_FLAG])
    else $error("port change flag not set");

  // A valid pin edge must leave its flag behind.
  a_pin_flag: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ev_pin |=> ctrl[B_PIN_FLAG])
    else $error("pin flag not set");

  // An edge of the unselected polarity must not raise the pin flag.
  // Software writes are excluded since they may set the flag on purpose.
  a_pin_wrong_edge: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    pin_chg[1] && pin_lvl[1] != option[B_EDGE_SEL] &&
    !ctrl[B_PIN_FLAG] && !wr_ctrl |=> !ctrl[B_PIN_FLAG])
    else $error("pin flag set on wrong edge");

  // Only software may clear the timer flag.
  a_tmr_kept: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ctrl[B_TMR_FLAG] && !wr_ctrl |=> ctrl[B_TMR_FLAG])
    else $error("timer flag cleared by hardware");

  // Only software may clear the port change flag.
  a_port_kept: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ctrl[B_PORT_FLAG] && !wr_ctrl |=> ctrl[B_PORT_FLAG])
    else $error("port flag cleared by hardware");

  // Only software may clear the conversion flag.
  a_conv_kept: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    pflag[B_CONV] && !wr_pflag |=> pflag[B_CONV])
    else $error("conversion flag cleared by hardware");

  // An enabled timer request must be taken at the first chance.
  // Nothing else may hold it back once the global enable is set.
  a_tmr_accept: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    phase_first && state == ST_RUN && ctrl[B_GLOBAL_EN] &&
    ctrl[B_TMR_FLAG] && ctrl[B_TMR_EN] |-> accept)
    else $error("enabled timer request not taken");

  // The conversion request passes once its own and the group enable agree.
  // Both gates are in the condition, so a missing group enable is caught by a_all_masked only when every other enable is clear too, not here.
  a_conv_accept: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    phase_first && state == ST_RUN && ctrl[B_GLOBAL_EN] &&
    pflag[B_CONV] && pen[B_CONV] && ctrl[B_PERIPH_EN] |-> accept)
    else $error("enabled conversion request not taken");

  // With every source masked no flag may cause a vector.
  // Flags still record their events while masked.
  a_all_masked: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !ctrl[B_TMR_EN] && !ctrl[B_PIN_EN] && !ctrl[B_PORT_EN] &&
    !ctrl[B_PERIPH_EN] |-> !accept)
    else $error("masked source caused a vector");

  // Requests are only looked at in the first phase of a cycle.
  a_accept_phase: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    accept |-> phase_first)
    else $error("request taken outside the first phase");

  // The vector always follows acceptance by the same count of clocks.
  // The length of the running instruction plays no part in it.
  a_lat_fixed: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    accept |-> ##4 vec_o.load)
    else $error("vector latency not fixed");

  // The core must discard fetches from the moment the vector is issued.
  a_vec_dummy: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    vec_o.load |-> dummy_o)
    else $error("vector without dummy cycles");

  // A plain write decides the global enable when nothing overrides it.
  a_gie_write: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_ctrl && !accept && !core_i.pop |=>
    ctrl[B_GLOBAL_EN] == $past(wdata_i[B_GLOBAL_EN]))
    else $error("global enable ignored a write");

  // The phase output steps once per clock and wraps.
  a_phase_step: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    1'b1 |=> phase_o == $past(phase_o) + 2'h1)
    else $error("phase did not advance");

  // Read data is zero whenever no read was asked for.
  a_rdata_idle: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !rd_i |=> rdata_o == BYTE_ZERO)
    else $error("read data without a read");

  // A control read returns the register as it stood at the strobe.
  a_rdata_ctrl: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_i && addr_i == ADDR_CTRL |=> rdata_o == $past(ctrl))
    else $error("control read returned wrong data");

  // No new request may be taken while the core discards fetches.
  a_no_accept_dummy: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    state == ST_DUMMY |-> !accept)
    else $error("request taken during dummy cycles");

  // The dummy counter must not run dry while dummy cycles are shown.
  a_dummy_count: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    dummy_o |-> dummy_cnt != 2'h0)
    else $error("dummy counter empty while discarding");

  // The discard output mirrors the state so the core never loses sync.
  a_state_dummy: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    1'b1 |-> dummy_o == (state == ST_DUMMY))
    else $error("dummy output out of step with state");

  // A vector is a single pulse, so the core pushes exactly once.
  a_vec_once: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    vec_o.load |=> !vec_o.load)
    else $error("vector pulse too long");

  // The pending request is consumed when the vector goes out.
  a_req_cleared: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    vec_o.load |-> !vec_req_q)
    else $error("vector request left pending");

  // The edge select must follow a write to the option register.
  a_opt_write: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_opt |=> option == $past(wdata_i))
    else $error("option write lost");

  // The conversion enable must follow a write to its register.
  a_pen_write: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_pen |=> pen == $past(wdata_i))
    else $error("peripheral enable write lost");
endmodule : mic_ctrl

// ---- bench/mic_core_model.sv ----
`timescale 1ns/1ps
module mic_core_model
  import mic_pkg::*;
(
  input  wire logic      clk_sys_i, // system clock
  input  wire logic      sys_rst_i, // synchronous reset
  input  wire logic      ret_i,     // bench asks for a return
  input  wire mic_vec_t  vec_i,     // vector request from block
  output mic_core_t      core_o,    // status back to block
  output logic     [3:0] depth_o    // return addresses held
);
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      core_o  <= '0;
      depth_o <= 4'h0;
    end
    else
    begin
      // An empty stack is not popped, so a stray return does no harm.
      core_o.pop <= ret_i && (depth_o != 4'h0);
      core_o.pc  <= vec_i.load ? vec_i.addr : core_o.pc + 13'h0001;
      if (vec_i.push)
        depth_o <= depth_o + 4'h1;
      else if (core_o.pop)
        depth_o <= depth_o - 4'h1;
    end
  end
endmodule : mic_core_model

// ---- bench/mic_ctrl_bench.sv ----
`timescale 1ns/1ps
module mic_ctrl_bench;
  import mic_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [1:0] addr      = 2'h0;
  logic [7:0] wdata     = 8'h00;
  logic       wr_s      = 1'b0;
  logic       rd_s      = 1'b0;
  logic       tmr       = 1'b0;
  logic       conv      = 1'b0;
  logic       pin       = 1'b0;
  logic [2:0] port      = 3'h0;
  logic       ret       = 1'b0;
  logic [7:0] rdata;
  mic_core_t  core;
  mic_vec_t   vec;
  logic       dummy;
  logic [1:0] phase;
  int         checks    = 0;
  int         fails     = 0;
  int         vcnt      = 0;

  mic_ctrl u_mic_ctrl (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .tmr_ovf_i(tmr), .conv_done_i(conv),
    .ext_irq_pin_i(pin), .port_pins_i(port), .core_i(core),
    .vec_o(vec), .dummy_o(dummy), .phase_o(phase));
  mic_core_model u_mic_core_model (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .ret_i(ret), .vec_i(vec), .core_o(core),
    .depth_o());

  initial
  begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i)
    if (vec.load === 1'b1)
      vcnt <= vcnt + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_sys_i);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd

  // Waits long enough to cover the pin synchroniser and a full latency.
  task automatic expect_vec(input int n);
    int v0;
    v0 = vcnt;
    repeat (24) @(posedge clk_sys_i);
    check(vcnt - v0, n);
  endtask : expect_vec

  task automatic t_reset;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_PFLAG, PERIPH_RESET);
    rd(ADDR_PEN, PERIPH_RESET);
    rd(ADDR_OPTION, OPTION_RESET);
  endtask : t_reset

  task automatic t_flags_masked;
    @(posedge clk_sys_i);
    tmr  <= 1'b1;
    conv <= 1'b1;
    pin  <= 1'b1;
    port <= 3'h4;
    @(posedge clk_sys_i);
    tmr  <= 1'b0;
    conv <= 1'b0;
    expect_vec(0);
    rd(ADDR_CTRL, 8'h07);
    rd(ADDR_PFLAG, 8'h40);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_PFLAG, 8'h00);
  endtask : t_flags_masked

  task automatic t_edge_sel;
    wr(ADDR_OPTION, 8'hBF);
    pin <= 1'b0;
    expect_vec(0);
    rd(ADDR_CTRL, 8'h02);
    wr(ADDR_CTRL, 8'h00);
    pin <= 1'b1;
    expect_vec(0);
    rd(ADDR_CTRL, 8'h00);
    wr(ADDR_OPTION, 8'hFF);
  endtask : t_edge_sel

  task automatic t_timer_vec;
    int lat;
    int dn;
    wr(ADDR_CTRL, 8'hA0);
    @(posedge clk_sys_i);
    tmr <= 1'b1;
    @(posedge clk_sys_i);
    tmr <= 1'b0;
    lat = 0;
    dn  = 0;
    while (vec.load !== 1'b1 && lat < 16)
    begin
      @(posedge clk_sys_i);
      #1 lat++;
    end
    check(lat <= 9, 1'b1);
    check(vec.addr, VECTOR_ADDR);
    check(vec.push, 1'b1);
    check(phase, 2'h0);
    while (dummy === 1'b1 && dn < 16)
    begin
      dn++;
      @(posedge clk_sys_i);
      #1;
    end
    check(dn, DUMMY_CYCLES * PHASES);
    rd(ADDR_CTRL, 8'h24);
  endtask : t_timer_vec

  task automatic t_return;
    @(posedge clk_sys_i);
    ret <= 1'b1;
    @(posedge clk_sys_i);
    ret <= 1'b0;
    expect_vec(1);
    rd(ADDR_CTRL, 8'h24);
    wr(ADDR_CTRL, 8'h84);
    expect_vec(0);
  endtask : t_return

  task automatic t_sources;
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_PFLAG, 8'h40);
    wr(ADDR_PEN, 8'h40);
    wr(ADDR_CTRL, 8'h80);
    expect_vec(0);
    wr(ADDR_CTRL, 8'hC0);
    expect_vec(1);
    wr(ADDR_PFLAG, 8'h00);
    wr(ADDR_CTRL, 8'h88);
    port <= 3'h5;
    expect_vec(1);
    wr(ADDR_CTRL, 8'h90);
    pin <= 1'b0;
    expect_vec(0);
    pin <= 1'b1;
    expect_vec(1);
    wr(ADDR_CTRL, 8'h80);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_CTRL, CTRL_RESET);
    expect_vec(0);
    rd(ADDR_CTRL, CTRL_RESET);
  endtask : t_sources

  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    fails++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_flags_masked();
    t_edge_sel();
    t_timer_vec();
    t_return();
    t_sources();
    conclude();
  end
endmodule : mic_ctrl_bench
